//--- pmc_cfg.svh
`ifndef PMC_CFG_SVH
`define PMC_CFG_SVH
// register byte address on the apb bus (printed offset is not a multiple of four)
`define PMC_IDX_POWER_CONTROL   8'h87
`define PMC_ADDR_POWER_CONTROL  12'h21c
// extra status register of our own: low-power mode view
`define PMC_ADDR_MODE_STATUS    12'h220
// bit positions inside power_control
`define PMC_BIT_BAUD_DOUBLE     7
`define PMC_BIT_FE_ACCESS       6
`define PMC_BIT_RESERVED        5
`define PMC_BIT_COLD_START      4
`define PMC_BIT_USER_FLAG_1     3
`define PMC_BIT_USER_FLAG_0     2
`define PMC_BIT_POWER_DOWN      1
`define PMC_BIT_CPU_SLEEP       0
// reset value of the non-cold-start bits
`define PMC_RESET_VALUE         8'h00
`define PMC_SERIAL_MODE2        2'h2
`define PMC_SERIAL_MODE1        2'h1
`define PMC_SERIAL_MODE3        2'h3
`endif

//--- pmc_pkg.sv
package pmc_pkg;
    // low-power state of the core
    typedef enum logic [1:0] {
        PMC_RUN,
        PMC_IDLE,
        PMC_POWER_DOWN
    } pmc_mode_type;
endpackage

//--- pmc_if.sv
`timescale 1ns/1ps
`default_nettype none
// link between the register core and the serial-option decoder
interface pmc_opt_if;
    logic       baud_double;   // doubling enabled
    logic       fe_access_sel; // frame error routing select
    logic [1:0] serial_mode;   // current serial mode
    logic       t1_baud_src;   // timer 1 overflow is the baud source
    logic       baud_x2;       // doubling really applies
    modport core (output baud_double, output fe_access_sel, output serial_mode, output t1_baud_src, input baud_x2);
    modport dec  (input baud_double, input fe_access_sel, input serial_mode, input t1_baud_src, output baud_x2);
endinterface
`default_nettype wire

//--- pmc_baud_dec.sv
`timescale 1ns/1ps
`default_nettype none
`include "pmc_cfg.svh"
// decides whether the baud doubling applies in the current serial mode
module pmc_baud_dec (
    pmc_opt_if.dec opt
);
    // when doubling is enabled, mode 2 always doubles; modes 1 and 3 only with timer 1 as source
    always_comb begin
        opt.baud_x2 = opt.baud_double &&
                      ((opt.serial_mode == `PMC_SERIAL_MODE2) ||
                       (((opt.serial_mode == `PMC_SERIAL_MODE1) ||
                         (opt.serial_mode == `PMC_SERIAL_MODE3)) && opt.t1_baud_src));
    end
endmodule
`default_nettype wire

//--- pmc_power_ctrl.sv
// Our own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "pmc_cfg.svh"
module pmc_power_ctrl (
    input  wire logic        clk,             // 20 mhz system clock
    input  wire logic        sys_rst,         // synchronous reset, any source
    input  wire logic        por_rst,         // high with sys_rst when reset is power-on
    input  wire logic        psel,            // apb select
    input  wire logic        penable,         // apb access phase
    input  wire logic        pwrite,          // apb direction
    input  wire logic [11:0] paddr,           // apb byte address
    input  wire logic [31:0] pwdata,          // apb write data
    output logic      [31:0] prdata,          // apb read data
    output logic             pready,          // apb ready
    output logic             pslverr,         // apb error
    input  wire logic        wake_irq,        // any enabled interrupt request
    input  wire logic [1:0]  serial_mode,     // serial port mode
    input  wire logic        t1_baud_src,     // timer 1 is baud source
    input  wire logic        serial_mode_bit0,// stored serial mode bit 0
    input  wire logic        frame_error_flag,// framing error flag
    output logic             cpu_clk_en,      // cpu clock gate
    output logic             periph_clk_en,   // peripheral clock gate
    output logic             isr_start,       // pulse: fetch waking isr, then resume
    output logic             baud_x2,         // serial baud doubling active
    output logic             serial_ctrl_bit7 // read view of serial control bit 7
);
    // all state of this block lives in one packed record:
    // - the power control byte as software sees it
    // - the low-power mode the core is in
    // - the registered bus answer (data, ready, error)
    // - the registered clock gates and the wake pulse
    // - the registered serial option views
    // every top-level output is a field of this record, so each one
    // comes straight from a flip-flop and never glitches while the
    // clock gates downstream sample it.
    // the price is one cycle of latency on the serial option views,
    // which the serial port tolerates since its settings change slowly.
    typedef struct packed {
        logic [7:0]               power_control; // register image
        pmc_pkg::pmc_mode_type    mode;          // current low-power state
        logic [31:0]              prdata;        // read data of the answer
        logic                     pready;        // one-cycle answer strobe
        logic                     pslverr;       // error, valid with pready
        logic                     cpu_clk_en;    // cpu clock may run
        logic                     periph_clk_en; // peripheral clocks may run
        logic                     isr_start;     // one-cycle wake pulse
        logic                     baud_x2;       // doubling in effect
        logic                     sc_bit7;       // serial control bit 7 view
    } pmc_state_type;

    pmc_state_type state_reg;  // all registered state
    pmc_state_type state_next; // next value
    pmc_opt_if     opt ();     // link to decoder

    // the option bits go to the decoder straight from the stored byte;
    // the serial mode and baud source come from the serial port pins.
    // the decoder is pure logic, its answer is registered below.
    assign opt.baud_double   = state_reg.power_control[`PMC_BIT_BAUD_DOUBLE];
    assign opt.fe_access_sel = state_reg.power_control[`PMC_BIT_FE_ACCESS];
    assign opt.serial_mode   = serial_mode;
    assign opt.t1_baud_src   = t1_baud_src;

    pmc_baud_dec u_dec (
        .opt (opt)
    );

    // true on the access phase of an apb transfer.
    // used for every register decode, so kept in one place; the
    // setup phase alone never changes any state.
    // true on the access phase of an apb transfer
    function automatic logic apb_hit(input logic sel, input logic en);
        apb_hit = sel && en;
    endfunction

    // next-state logic.
    // bus walk: setup at one edge, access phase at the next; the edge
    // that sees the access phase with no answer pending takes the
    // request, updates the byte and raises pready for one cycle.
    // the master drops psel and penable at the edge that sees pready,
    // and the pending answer blocks a second take of the same access.
    // low-power entry: a write with the power-down bit set always wins
    // over the idle bit, and the idle bit is cleared at once so that
    // the core does not fall into idle when power-down ends.
    // wake: any enabled interrupt ends either low-power state; the
    // request bits clear and a one-cycle pulse tells the core to fetch
    // the waking service routine before it resumes after the sleep.
    // wake is placed after the bus decode, so it wins over a write of
    // the request bits in the same cycle; a sleeping core cannot write
    // anyway, so this only matters for a late bus access.
    // limitation: writes to the status word are refused with an error,
    // and any other address answers zero data with an error.
    always_comb begin
        logic [7:0] w; // incoming byte
        w = pwdata[7:0];
        state_next = state_reg;
        state_next.pready    = 1'b0;
        state_next.pslverr   = 1'b0;
        state_next.isr_start = 1'b0;
        // apb answers one cycle after the access phase begins
        if (apb_hit(psel, penable) && !state_reg.pready) begin
            state_next.pready = 1'b1;
            if (paddr == `PMC_ADDR_POWER_CONTROL) begin
                state_next.prdata = {24'h000000, state_reg.power_control};
                if (pwrite) begin
                    // reserved bit keeps its stored value whatever is written
                    w[`PMC_BIT_RESERVED] = state_reg.power_control[`PMC_BIT_RESERVED];
                    state_next.power_control = w;
                    // power-down wins when both requests land together
                    if (w[`PMC_BIT_POWER_DOWN]) begin
                        state_next.power_control[`PMC_BIT_CPU_SLEEP] = 1'b0;
                        state_next.mode = pmc_pkg::PMC_POWER_DOWN;
                    end else if (w[`PMC_BIT_CPU_SLEEP]) begin
                        state_next.mode = pmc_pkg::PMC_IDLE;
                    end
                end
            end else if (paddr == `PMC_ADDR_MODE_STATUS) begin
                state_next.prdata = {30'h0, state_reg.mode};
                state_next.pslverr = pwrite; // status is read-only
            end else begin
                // unmapped address: zero data with an error
                state_next.prdata  = 32'h00000000;
                state_next.pslverr = 1'b1;
            end
        end
        // wake: clocks restart and the isr is fetched next, then code resumes
        if (wake_irq && state_reg.mode != pmc_pkg::PMC_RUN) begin
            state_next.mode = pmc_pkg::PMC_RUN;
            state_next.power_control[`PMC_BIT_POWER_DOWN] = 1'b0;
            state_next.power_control[`PMC_BIT_CPU_SLEEP]  = 1'b0;
            state_next.isr_start = 1'b1;
        end
        // clock gates follow the next mode so they change with the state
        state_next.cpu_clk_en    = (state_next.mode == pmc_pkg::PMC_RUN);
        state_next.periph_clk_en = (state_next.mode != pmc_pkg::PMC_POWER_DOWN);
        state_next.baud_x2 = opt.baud_x2;
        // the select travels with the other options through the link
        state_next.sc_bit7 = opt.fe_access_sel ? frame_error_flag
                                               : serial_mode_bit0;
    end

    // state register; among resets only power-on reset moves the cold-start flag.
    // every reset clears the other bits and returns the core to run
    // with both clock gates open, so a reset never leaves it asleep.
    // the cold-start flag is set by power-on reset and simply kept by
    // any other reset; software must clear it itself if it wants to
    // tell a later warm reset apart from a cold start.
    // reset is synchronous: it needs at least one clock edge while high.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= '0;
            state_reg.power_control <= `PMC_RESET_VALUE;
            state_reg.mode <= pmc_pkg::PMC_RUN;
            state_reg.cpu_clk_en <= 1'b1;
            state_reg.periph_clk_en <= 1'b1;
            if (por_rst) begin
                state_reg.power_control[`PMC_BIT_COLD_START] <= 1'b1;
            end else begin
                state_reg.power_control[`PMC_BIT_COLD_START] <=
                    state_reg.power_control[`PMC_BIT_COLD_START];
            end
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs are plain wires from the state record, no logic between.
    // the clock gates are level signals: one means the clock may run.
    // isr_start and pready are one-cycle pulses; prdata and pslverr
    // are only meaningful while pready is high.
    assign prdata           = state_reg.prdata;
    assign pready           = state_reg.pready;
    assign pslverr          = state_reg.pslverr;
    assign cpu_clk_en       = state_reg.cpu_clk_en;
    assign periph_clk_en    = state_reg.periph_clk_en;
    assign isr_start        = state_reg.isr_start;
    assign baud_x2          = state_reg.baud_x2;
    assign serial_ctrl_bit7 = state_reg.sc_bit7;
endmodule
`default_nettype wire

//--- pmc_power_ctrl_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "pmc_cfg.svh"
// watches handshake, clock gates and serial options at the ports
module pmc_power_ctrl_checker (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        wake_irq,
    input wire logic [1:0]  serial_mode,
    input wire logic        t1_baud_src,
    input wire logic        serial_mode_bit0,
    input wire logic        frame_error_flag,
    input wire logic        cpu_clk_en,
    input wire logic        periph_clk_en,
    input wire logic        isr_start,
    input wire logic        baud_x2,
    input wire logic        serial_ctrl_bit7
);
    logic rst_q;  // reset seen at the previous edge
    // registered outputs still show reset values one edge after release
    always_ff @(posedge clk) begin
        rst_q <= sys_rst;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst || rst_q);
    logic acc;    // access phase not yet answered
    logic wr_run; // request write while running, wake has priority otherwise
    assign acc    = psel && penable && !pready;
    assign wr_run = acc && pwrite && paddr == `PMC_ADDR_POWER_CONTROL && cpu_clk_en && !wake_irq;
    ready_lat_a: assert property (acc |=> pready) else $error("ready late");
    ready_pulse_a: assert property (pready |=> !pready) else $error("ready stuck");
    unmapped_err_a: assert property (acc && paddr > `PMC_ADDR_MODE_STATUS |=> pslverr && prdata == 32'h0) else $error("unmapped");
    status_ro_a: assert property (acc && pwrite && paddr == `PMC_ADDR_MODE_STATUS |=> pslverr) else $error("status wr");
    pd_entry_a: assert property (wr_run && pwdata[1] |=> !cpu_clk_en && !periph_clk_en) else $error("pd");
    idle_entry_a: assert property (wr_run && pwdata[1:0] == 2'h1 |=> !cpu_clk_en && periph_clk_en) else $error("idle");
    wake_up_a: assert property (!cpu_clk_en && wake_irq |=> cpu_clk_en && periph_clk_en && isr_start) else $error("wake");
    isr_pulse_a: assert property (isr_start |=> !isr_start) else $error("isr long");
    gate_order_a: assert property (!periph_clk_en |-> !cpu_clk_en) else $error("gates");
    no_double_a: assert property (serial_mode == 2'h0 || (serial_mode[0] && !t1_baud_src) |=> !baud_x2) else $error("x2");
    fe_route_a: assert property (serial_mode_bit0 == frame_error_flag |=> serial_ctrl_bit7 == $past(frame_error_flag)) else $error("bit7");
endmodule
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "pmc_cfg.svh"
module tb_top;
    logic        clk, sys_rst, por_rst, psel, penable, pwrite, wake_irq, t1_baud_src, frame_error_flag;
    logic        serial_mode_bit0, pready, pslverr, cpu_clk_en, periph_clk_en, isr_start, baud_x2, serial_ctrl_bit7, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0]  serial_mode;
    int          n_mismatch, n_compared;
    pmc_power_ctrl i_pmc_power_ctrl (
        .clk (clk), .sys_rst (sys_rst), .por_rst (por_rst), .psel (psel), .penable (penable),
        .pwrite (pwrite), .paddr (paddr), .pwdata (pwdata), .prdata (prdata), .pready (pready),
        .pslverr (pslverr), .wake_irq (wake_irq), .serial_mode (serial_mode), .t1_baud_src (t1_baud_src),
        .serial_mode_bit0 (serial_mode_bit0), .frame_error_flag (frame_error_flag), .cpu_clk_en (cpu_clk_en),
        .periph_clk_en (periph_clk_en), .isr_start (isr_start), .baud_x2 (baud_x2),
        .serial_ctrl_bit7 (serial_ctrl_bit7)
    );
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic report_and_stop;
        if (n_mismatch == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // one apb transfer, held until pready is seen at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        int n;
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do @(posedge clk); while (pready !== 1'b1 && ++n < 20);
        if (n >= 20) n_mismatch++;
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 8'h00);
        check(nm, rd, e);
    endtask
    task automatic do_reset(input logic por);
        @(posedge clk);
        sys_rst <= 1'b1;
        por_rst <= por;
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        por_rst <= 1'b0;
    endtask
    // cold flag across resets; unmapped address must answer an error
    task automatic t_regs;
        rdchk("cold", `PMC_ADDR_POWER_CONTROL, 32'h10);
        apb(1'b1, `PMC_ADDR_POWER_CONTROL, 8'hdc);
        rdchk("flags", `PMC_ADDR_POWER_CONTROL, 32'hdc);
        do_reset(1'b0);
        rdchk("warm", `PMC_ADDR_POWER_CONTROL, 32'h10);
        apb(1'b1, `PMC_ADDR_POWER_CONTROL, 8'h00);
        do_reset(1'b0);
        rdchk("clear", `PMC_ADDR_POWER_CONTROL, 32'h00);
        apb(1'b0, 12'h300, 8'h00);
        check("unmapped", {31'h0, err}, 32'h1);
    endtask
    // enter a low-power state, then wake it with one interrupt pulse
    task automatic t_sleep(input logic [7:0] req);
        apb(1'b1, `PMC_ADDR_POWER_CONTROL, req);
        check("gates", {30'h0, cpu_clk_en, periph_clk_en}, {31'h0, !req[1]});
        rdchk("req", `PMC_ADDR_POWER_CONTROL, {30'h0, req[1], !req[1]});
        @(posedge clk);
        wake_irq <= 1'b1;
        @(posedge clk);
        wake_irq <= 1'b0;
        #1 check("isr", {29'h0, isr_start, cpu_clk_en, periph_clk_en}, 32'h7);
        rdchk("woke", `PMC_ADDR_POWER_CONTROL, 32'h0);
    endtask
    // doubling over every mode, source and enable, then bit 7 routing
    task automatic t_serial;
        for (int i = 0; i < 16; i++) begin
            apb(1'b1, `PMC_ADDR_POWER_CONTROL, {i[3], 7'h0});
            serial_mode <= i[1:0];
            t1_baud_src <= i[2];
            @(posedge clk);
            #1 check("x2", {31'h0, baud_x2}, {31'h0, i[3] && (i[1:0] == 2'h2 || (i[0] && i[2]))});
        end
        for (int s = 0; s < 2; s++) begin
            apb(1'b1, `PMC_ADDR_POWER_CONTROL, {1'b0, s[0], 6'h0});
            serial_mode_bit0 <= 1'b0;
            @(posedge clk);
            #1 check("bit7", {31'h0, serial_ctrl_bit7}, {31'h0, s[0]});
        end
    endtask
    initial begin
        {psel, penable, pwrite, wake_irq, t1_baud_src, frame_error_flag, serial_mode_bit0} = 7'h03;
        {sys_rst, por_rst, paddr, pwdata, serial_mode} = {2'h3, 46'h0};
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        por_rst <= 1'b0;
        t_regs;
        t_sleep(8'h02);
        t_sleep(8'h01);
        t_sleep(8'h03);
        t_serial;
        report_and_stop;
    end
    // cuts a hang well past the fewer than two hundred cycles the tests need
    initial begin
        repeat (3000) @(posedge clk);
        n_mismatch++;
        report_and_stop;
    end
endmodule
bind pmc_power_ctrl pmc_power_ctrl_checker i_pmc_power_ctrl_checker (
    .clk (clk), .sys_rst (sys_rst), .psel (psel), .penable (penable), .pwrite (pwrite), .paddr (paddr),
    .pwdata (pwdata), .prdata (prdata), .pready (pready), .pslverr (pslverr), .wake_irq (wake_irq),
    .serial_mode (serial_mode), .t1_baud_src (t1_baud_src), .serial_mode_bit0 (serial_mode_bit0),
    .frame_error_flag (frame_error_flag), .cpu_clk_en (cpu_clk_en), .periph_clk_en (periph_clk_en),
    .isr_start (isr_start), .baud_x2 (baud_x2), .serial_ctrl_bit7 (serial_ctrl_bit7)
);
`default_nettype wire
